// *** design/cpu_regs_pkg.sv ***
// Shared types and constants for the CPU programmer-visible register set
package cpu_regs_pkg;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] SP_RESET     = 16'h00ff;  // Stack pointer after reset
  localparam logic [7:0]  SP_LOW_RESET = 8'hff;     // Low byte loaded by the low-reset instruction
  localparam logic [7:0]  H_RESET      = 8'h00;     // Upper index byte after reset
  localparam logic [7:0]  FLAGS_RESET  = 8'h68;     // Ones bits plus interrupt mask set
  localparam logic [7:0]  FLAGS_ONES   = 8'h60;     // Bits 6 and 5 always read one
  localparam logic [15:0] VEC_RESET_HI = 16'hfffe;  // Reset vector, high byte address
  localparam logic [15:0] VEC_RESET_LO = 16'hffff;  // Reset vector, low byte address
  localparam logic [2:0]  PUSH_LAST    = 3'h4;      // Index of the last byte pushed on entry

  // ----------------------------------------------------------------
  // Condition flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_V = 7;  // Two's complement overflow
  localparam int FLAG_H = 4;  // Half carry
  localparam int FLAG_I = 3;  // Interrupt mask
  localparam int FLAG_N = 2;  // Negative
  localparam int FLAG_Z = 1;  // Zero
  localparam int FLAG_C = 0;  // Carry or borrow

  // ----------------------------------------------------------------
  // Debug APB map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_ACC   = 12'h000;  // Accumulator view
  localparam logic [11:0] OFS_INDEX = 12'h004;  // Index pair view
  localparam logic [11:0] OFS_SP    = 12'h008;  // Stack pointer view
  localparam logic [11:0] OFS_PC    = 12'h00c;  // Program counter view
  localparam logic [11:0] OFS_FLAGS = 12'h010;  // Condition flags view
  localparam logic [11:0] OFS_CTRL  = 12'h014;  // Control, bit 0 freezes command intake
  localparam int          CTRL_FREEZE = 0;      // Freeze bit position

  // ----------------------------------------------------------------
  // Sequencer operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_FETCH, OP_JUMP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_LDA,
    OP_LDX, OP_LDHX, OP_TEST8, OP_TEST16, OP_SHIFT, OP_CARRY, OP_LDSP,
    OP_STACK_ADJUST, OP_STACK_LOW_RESET, OP_DECIMAL_ADJUST, OP_MASK_CLEAR,
    OP_MASK_SET, OP_TAP, OP_TPA
  } op_t;

  // Command from the instruction sequencer
  typedef struct packed {
    op_t         op;    // Operation
    logic [15:0] data;  // Operand, ALU result or address
  } cmd_t;

  // Snapshot of the register set
  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] index;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flags;
  } regs_t;

  // Byte memory request for stacking and vector fetch
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

endpackage : cpu_regs_pkg

// *** design/cpu_register_file.sv ***
// CPU register set, condition flags, interrupt entry and reset vector load
//
// Functional notes
// - Accumulator eight bits, feeds ALU, reset-transparent
// - Index pair is two bytes, used whole
// - Reset clears upper index byte only
// - Stack pointer addresses next free location
// - Stack adjust adds sign-extended immediate
// - Stack pointer resets to 00ff
// - Stack low reset changes low byte only
// - Program counter increments per fetch unless loaded
// - Reset loads program counter from top vector
// - Flag bits 6 and 5 always one
// - Bit 7 marks signed overflow
// - Bit 4 marks carry from bit 3
// - Decimal adjust corrects using half and carry
// - Mask bit blocks maskable interrupts
// - Mask set after stacking, before handler
// - No interrupt right after mask clear
// - Bit 2 copies result sign bit
// - Bit 1 set on all-zero value
// - Bit 0 is carry or borrow
// - Registers not in the CPU memory map
// - Entry stacks pc low, pc high, x, acc, flags
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cpu_register_file (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  // Sequencer command port
  input  wire logic                   cmd_valid,
  input  wire cpu_regs_pkg::cmd_t     cmd,
  output logic                        cmd_ready,
  input  wire logic                   instr_done,
  // Interrupt request and vector
  input  wire logic                   irq_req,
  input  wire logic [15:0]            irq_vec_addr,
  output logic                        irq_take,
  // Register view for ALU and address generation
  output cpu_regs_pkg::regs_t         regs,
  // Byte memory port for stacking and vectors
  output logic                        mem_valid,
  output cpu_regs_pkg::mem_req_t      mem_req,
  input  wire logic                   mem_ready,
  input  wire logic [7:0]             mem_rdata,
  // Debug APB slave
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr
);
  import cpu_regs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_RVEC_HI, S_RVEC_LO, S_RUN, S_PUSH, S_IVEC_HI, S_IVEC_LO} state_t;

  state_t      state_q, state_d;       // Sequencing state
  logic [2:0]  push_idx_q;             // Byte being stacked
  logic [7:0]  acc_q, acc_d;           // Accumulator
  logic [7:0]  hi_q, hi_d;             // Upper index byte
  logic [7:0]  lo_q, lo_d;             // Lower index byte
  logic [15:0] sp_q, sp_d;             // Stack pointer
  logic [15:0] pc_q, pc_d;             // Program counter
  logic [7:0]  flags_q, flags_d;       // Condition flags
  logic        inhibit_q;              // Blocks one boundary after mask clear
  logic        freeze_q;               // Debug freeze of command intake
  logic [31:0] prdata_q;               // Registered read data
  logic        pslverr_q;              // Registered error answer
  logic        cmd_take;               // Command accepted this cycle
  logic        mask_clr_take;          // Mask clear or transfer taken
  logic        mem_done;               // Memory handshake completes
  logic [8:0]  sum9;                   // Byte add or subtract with carry out
  logic [4:0]  half5;                  // Low nibble add with carry out
  logic [7:0]  daa_corr;               // Decimal correction
  logic        cin;                    // Carry into add or subtract
  logic [7:0]  opnd;                   // Byte operand

  // Zero test on a byte
  function automatic logic zero8(input logic [7:0] v);
    return (v == 8'h00);
  endfunction : zero8

  // Sign extension of an 8-bit immediate
  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction : sext8

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign cmd_ready = (state_q == S_RUN) && !freeze_q;
  assign cmd_take  = cmd_valid && cmd_ready;
  assign mem_valid = (state_q != S_RUN);
  assign mem_done  = mem_valid && mem_ready;
  assign mask_clr_take = cmd_take && ((cmd.op == OP_MASK_CLEAR) || (cmd.op == OP_TAP));
  assign irq_take = (state_q == S_RUN) && instr_done && irq_req && !flags_q[FLAG_I]
                    && !inhibit_q && !mask_clr_take;
  assign opnd = cmd.data[7:0];
  // accumulator and whole index on view
  assign regs = '{acc: acc_q, index: {hi_q, lo_q}, sp: sp_q, pc: pc_q, flags: flags_q};

  // Memory request contents per state
  always_comb begin
    mem_req = '{we: 1'b0, addr: 16'h0000, wdata: 8'h00};
    unique case (state_q)
      S_RVEC_HI: mem_req.addr = VEC_RESET_HI;
      S_RVEC_LO: mem_req.addr = VEC_RESET_LO;
      S_IVEC_HI: mem_req.addr = irq_vec_addr;
      S_IVEC_LO: mem_req.addr = irq_vec_addr + 16'h0001;
      // stack at next free slot, fixed order
      S_PUSH: begin
        mem_req.we   = 1'b1;
        mem_req.addr = sp_q;
        unique case (push_idx_q)
          3'h0:    mem_req.wdata = pc_q[7:0];
          3'h1:    mem_req.wdata = pc_q[15:8];
          3'h2:    mem_req.wdata = lo_q;
          3'h3:    mem_req.wdata = acc_q;
          default: mem_req.wdata = flags_q;
        endcase
      end
      S_RUN: mem_req.addr = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Datapath next values
  // ----------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    hi_d = hi_q;
    lo_d = lo_q;
    sp_d = sp_q;
    pc_d = pc_q;
    flags_d = flags_q;
    cin = 1'b0;
    sum9 = 9'h000;
    half5 = 5'h00;
    daa_corr = 8'h00;
    unique case (state_q)
      S_RVEC_HI, S_IVEC_HI: begin
        if (mem_done) begin
          pc_d[15:8] = mem_rdata;
        end
      end
      S_RVEC_LO, S_IVEC_LO: begin
        if (mem_done) begin
          pc_d[7:0] = mem_rdata;
        end
      end
      S_PUSH: begin
        if (mem_done) begin
          sp_d = sp_q - 16'h0001;
          // mask only after last byte stacked
          if (push_idx_q == PUSH_LAST) begin
            flags_d[FLAG_I] = 1'b1;
          end
        end
      end
      S_RUN: begin
        if (cmd_take) begin
          unique case (cmd.op)
            OP_NOP: acc_d = acc_q;
            // sequential advance or change of flow
            OP_FETCH: pc_d = pc_q + 16'h0001;
            OP_JUMP:  pc_d = cmd.data;
            OP_ADD, OP_ADC: begin
              cin   = (cmd.op == OP_ADC) && flags_q[FLAG_C];
              sum9  = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin};
              half5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
              acc_d = sum9[7:0];
              flags_d[FLAG_V] = (acc_q[7] == opnd[7]) && (sum9[7] != acc_q[7]);
              flags_d[FLAG_H] = half5[4];
              flags_d[FLAG_N] = sum9[7];
              flags_d[FLAG_Z] = zero8(sum9[7:0]);
              flags_d[FLAG_C] = sum9[8];
            end
            OP_SUB, OP_SBC: begin
              cin   = (cmd.op == OP_SBC) && flags_q[FLAG_C];
              sum9  = {1'b0, acc_q} - {1'b0, opnd} - {8'h00, cin};
              acc_d = sum9[7:0];
              flags_d[FLAG_V] = (acc_q[7] != opnd[7]) && (sum9[7] != acc_q[7]);
              flags_d[FLAG_N] = sum9[7];
              flags_d[FLAG_Z] = zero8(sum9[7:0]);
              flags_d[FLAG_C] = sum9[8];
            end
            // Loads and logic results, overflow cleared
            OP_LDA: begin
              acc_d = opnd;
              flags_d[FLAG_V] = 1'b0;
              flags_d[FLAG_N] = opnd[7];
              flags_d[FLAG_Z] = zero8(opnd);
            end
            OP_LDX: begin
              lo_d = opnd;
              flags_d[FLAG_V] = 1'b0;
              flags_d[FLAG_N] = opnd[7];
              flags_d[FLAG_Z] = zero8(opnd);
            end
            OP_LDHX: begin
              {hi_d, lo_d} = cmd.data;
              flags_d[FLAG_V] = 1'b0;
              flags_d[FLAG_N] = cmd.data[15];
              flags_d[FLAG_Z] = (cmd.data == 16'h0000);
            end
            // Stored value tests
            OP_TEST8: begin
              flags_d[FLAG_V] = 1'b0;
              flags_d[FLAG_N] = opnd[7];
              flags_d[FLAG_Z] = zero8(opnd);
            end
            OP_TEST16: begin
              flags_d[FLAG_V] = 1'b0;
              flags_d[FLAG_N] = cmd.data[15];
              flags_d[FLAG_Z] = (cmd.data == 16'h0000);
            end
            // shift result, bit 8 is the shifted-out bit
            OP_SHIFT: begin
              acc_d = opnd;
              flags_d[FLAG_C] = cmd.data[8];
              flags_d[FLAG_N] = opnd[7];
              flags_d[FLAG_Z] = zero8(opnd);
              flags_d[FLAG_V] = opnd[7] ^ cmd.data[8];
            end
            OP_CARRY: flags_d[FLAG_C] = cmd.data[0];
            OP_LDSP: sp_d = cmd.data;
            OP_STACK_ADJUST: sp_d = sp_q + sext8(opnd);
            OP_STACK_LOW_RESET: sp_d = {sp_q[15:8], SP_LOW_RESET};
            // decimal correction from half and carry
            OP_DECIMAL_ADJUST: begin
              daa_corr[3:0] = (flags_q[FLAG_H] || (acc_q[3:0] > 4'h9)) ? 4'h6 : 4'h0;
              daa_corr[7:4] = (flags_q[FLAG_C] || (acc_q > 8'h99)) ? 4'h6 : 4'h0;
              acc_d = acc_q + daa_corr;
              flags_d[FLAG_C] = flags_q[FLAG_C] || (acc_q > 8'h99);
              flags_d[FLAG_N] = acc_d[7];
              flags_d[FLAG_Z] = zero8(acc_d);
            end
            OP_MASK_CLEAR: flags_d[FLAG_I] = 1'b0;
            OP_MASK_SET:   flags_d[FLAG_I] = 1'b1;
            OP_TAP:        flags_d = acc_q;
            OP_TPA:        acc_d = flags_q;
          endcase
        end
      end
    endcase
    flags_d = flags_d | FLAGS_ONES;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // accumulator has no reset
  always_ff @(posedge clk_sys) begin
    acc_q <= acc_d;
  end

  // lower index byte keeps contents over reset
  always_ff @(posedge clk_sys) begin
    lo_q <= lo_d;
  end

  // upper index byte cleared by reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_q <= H_RESET;
    end else begin
      hi_q <= hi_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sp_q <= SP_RESET;
    end else begin
      sp_q <= sp_d;
    end
  end

  // Program counter, vector loaded after reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_q <= 16'h0000;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Condition flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // one boundary held off, set wins over clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inhibit_q <= 1'b0;
    end else if (mask_clr_take) begin
      inhibit_q <= 1'b1;
    end else if (instr_done) begin
      inhibit_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_RVEC_HI: if (mem_done) state_d = S_RVEC_LO;
      S_RVEC_LO: if (mem_done) state_d = S_RUN;
      S_RUN:     if (irq_take) state_d = S_PUSH;
      S_PUSH:    if (mem_done && (push_idx_q == PUSH_LAST)) state_d = S_IVEC_HI;
      S_IVEC_HI: if (mem_done) state_d = S_IVEC_LO;
      S_IVEC_LO: if (mem_done) state_d = S_RUN;
    endcase
  end

  // State and push counter
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q    <= S_RVEC_HI;
      push_idx_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (state_q != S_PUSH) begin
        push_idx_q <= 3'h0;
      end else if (mem_done) begin
        push_idx_q <= push_idx_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Debug APB slave, separate from the CPU memory map
  // ----------------------------------------------------------------
  // views only reachable here, never by load or store
  assign pready  = psel && penable;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // Read data and error captured in setup phase, zero wait access
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      unique case (paddr)
        OFS_ACC:   prdata_q <= {24'h00_0000, acc_q};
        OFS_INDEX: prdata_q <= {16'h0000, hi_q, lo_q};
        OFS_SP:    prdata_q <= {16'h0000, sp_q};
        OFS_PC:    prdata_q <= {16'h0000, pc_q};
        OFS_FLAGS: prdata_q <= {24'h00_0000, flags_q};
        OFS_CTRL:  prdata_q <= {31'h0000_0000, freeze_q};
        default:   pslverr_q <= 1'b1;
      endcase
    end
  end

  // Freeze control steers command intake
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      freeze_q <= 1'b0;
    end else if (psel && penable && pwrite && (paddr == OFS_CTRL)) begin
      freeze_q <= pwdata[CTRL_FREEZE];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_last_push;
    (state_q == S_PUSH) && (push_idx_q == PUSH_LAST) && mem_ready;
  endsequence

  sequence s_vector_start;
    (state_q == S_IVEC_HI) && flags_q[FLAG_I];
  endsequence

  ones_bits_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    flags_q[6:5] == 2'b11) else $error("Fixed flag bits not one");

  fetch_advance_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_take && (cmd.op == OP_FETCH) |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("Program counter did not advance on fetch");

  stack_adjust_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_take && (cmd.op == OP_STACK_ADJUST) |=> sp_q == $past(sp_q) + {{8{$past(cmd.data[7])}}, $past(cmd.data[7:0])})
    else $error("Stack adjust result wrong");

  stack_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_take && (cmd.op == OP_STACK_LOW_RESET) |=> (sp_q[15:8] == $past(sp_q[15:8])) && (sp_q[7:0] == 8'hff))
    else $error("Stack low reset touched high byte");

  half_carry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_take && (cmd.op == OP_ADD) |=> flags_q[FLAG_H] == ((5'({1'b0, $past(acc_q[3:0])}) + 5'({1'b0, $past(cmd.data[3:0])})) > 5'h0f))
    else $error("Half carry wrong after add");

  add_carry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_take && (cmd.op == OP_ADD) |=> flags_q[FLAG_C] == ((9'({1'b0, $past(acc_q)}) + 9'({1'b0, $past(cmd.data[7:0])})) > 9'h0ff))
    else $error("Carry wrong after add");

  zero_sign_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_take && (cmd.op == OP_LDHX) |=> (flags_q[FLAG_Z] == ($past(cmd.data) == 16'h0000)) && (flags_q[FLAG_N] == $past(cmd.data[15])))
    else $error("Zero or negative wrong on 16-bit load");

  mask_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    irq_take |-> !flags_q[FLAG_I] && !inhibit_q) else $error("Interrupt taken while masked");

  entry_order_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    irq_take |=> mem_valid && mem_req.we && (mem_req.wdata == $past(pc_q[7:0])) && (mem_req.addr == $past(sp_q)))
    else $error("First stacked byte not program counter low");

  mask_after_push_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_last_push |=> s_vector_start) else $error("Mask not set after stacking");

  vector_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == S_RVEC_LO) && mem_ready |-> (mem_req.addr == VEC_RESET_LO) ##1 (state_q == S_RUN) && (pc_q[7:0] == $past(mem_rdata)))
    else $error("Reset vector low byte not loaded");

  no_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == S_RUN) |-> !mem_valid) else $error("Memory access while running commands");

endmodule : cpu_register_file

`default_nettype wire

// *** test/mem_model.sv ***
// Byte memory partner answering stacking and vector fetches
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock and pacing
  input  wire logic                   clk_sys,
  input  wire logic                   slow,
  // Memory port
  input  wire logic                   mem_valid,
  input  wire cpu_regs_pkg::mem_req_t mem_req,
  output logic                        mem_ready,
  output logic [7:0]                  mem_rdata
);
  import cpu_regs_pkg::*;
  logic [7:0] m [0:65535];  // Byte store
  logic       go;           // Answer now
  // Data not valid outside the answer cycle, so show its inverse
  assign mem_ready = mem_valid & go;
  assign mem_rdata = mem_ready ? m[mem_req.addr] : ~m[mem_req.addr];
  initial begin
    go = 1'b1;
    m[16'hfffe] = 8'h12;
    m[16'hffff] = 8'h34;
    m[16'hfff8] = 8'h56;
    m[16'hfff9] = 8'h78;
  end
  // Random stalls in slow mode; writes land on completion
  always @(posedge clk_sys) begin
    go <= slow ? 1'($urandom % 2) : 1'b1;
    if (mem_ready && mem_req.we) m[mem_req.addr] <= mem_req.wdata;
  end
endmodule : mem_model
`default_nettype wire

// *** test/cpu_register_file_flags_test.sv ***
// Self-checking bench for the CPU register set
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_flags_test;
  import cpu_regs_pkg::*;
  logic clk_sys = 0, resetn = 0, cmd_valid = 0, instr_done = 0, irq_req = 0, slow = 0;
  logic psel = 0, penable = 0, pwrite = 0, cmd_ready, irq_take, mem_valid, mem_ready, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] prdata;
  logic [31:0] pwdata = '0;
  logic [7:0]  mem_rdata;
  cmd_t        cmd = '0;
  regs_t       regs;
  mem_req_t    mem_req;
  int          fails = 0, comparisons = 0, cyc = 0, a, d, s, fl;
  logic [7:0]  pushed [5] = '{8'h34, 8'h12, 8'h5c, 8'h3c, 8'h60};
  cpu_register_file dut_u (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .instr_done(instr_done), .irq_req(irq_req), .irq_vec_addr(16'hfff8),
    .irq_take(irq_take), .regs(regs), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  mem_model mem_u (.clk_sys(clk_sys), .slow(slow), .mem_valid(mem_valid), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  always #50 clk_sys = ~clk_sys;
  task automatic results();
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One command, held until taken
  task automatic run(input op_t op, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{op, v};
    do @(negedge clk_sys); while (cmd_ready !== 1'b1 && n++ < 300);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    @(negedge clk_sys);
  endtask : run
  task automatic bound(output logic t);
    @(posedge clk_sys);
    instr_done <= 1'b1;
    @(negedge clk_sys);
    t = irq_take;
    @(posedge clk_sys);
    instr_done <= 1'b0;
  endtask : bound
  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(negedge clk_sys); while (pready !== 1'b1 && n++ < 50);
    @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    logic [31:0] q;
    logic e;
    logic t;
    void'($urandom(79752));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    run(OP_MASK_CLEAR, 16'h0);
    chk(regs.pc, 32'h1234);
    chk(regs.sp, 32'h00ff);
    chk(regs.index[15:8], 32'h0);
    chk(regs.flags, 32'h60);
    apb(1'b0, OFS_SP, 32'h0, q, e);
    chk(q, 32'h00ff);
    chk(e, 0);
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk(e, 1);
    // Freeze through the debug port holds off commands
    apb(1'b1, OFS_CTRL, 32'h1, q, e);
    apb(1'b0, OFS_CTRL, 32'h0, q, e);
    chk(q, 32'h1);
    @(negedge clk_sys);
    chk(cmd_ready, 0);
    apb(1'b1, OFS_CTRL, 32'h0, q, e);
    // Adds with a zero-and-carry boundary first
    for (int i = 0; i < 8; i++) begin
      a = $urandom % 256;
      d = (i == 0) ? (256 - a) % 256 : $urandom % 256;
      run(OP_LDA, 16'(a));
      run(OP_ADD, 16'(d));
      s = a + d;
      fl = 8'h60 | ((a[7] == d[7] && s[7] != a[7]) << 7) | ((((a % 16) + (d % 16)) / 16) << 4);
      fl = fl | (s[7] << 2) | ((s % 256 == 0) << 1) | (s / 256);
      chk(regs.acc, s % 256);
      chk(regs.flags, fl);
    end
    // Decimal adjust after a half carry, then a borrow
    run(OP_LDA, 16'h19);
    run(OP_ADD, 16'h28);
    run(OP_DECIMAL_ADJUST, 16'h0);
    chk(regs.acc, 32'h47);
    chk(regs.flags, 32'h70);
    run(OP_LDA, 16'h10);
    run(OP_SUB, 16'h20);
    chk(regs.acc, 32'hf0);
    chk(regs.flags, 32'h75);
    run(OP_LDHX, 16'hab00);
    run(OP_LDX, 16'h5c);
    chk(regs.index, 32'hab5c);
    run(OP_LDA, 16'h3c);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    run(OP_MASK_CLEAR, 16'h0);
    chk(regs.index, 32'h005c);
    chk(regs.acc, 32'h3c);
    chk(regs.sp, 32'h00ff);
    run(OP_LDSP, 16'h1280);
    run(OP_STACK_ADJUST, 16'h00fe);
    chk(regs.sp, 32'h127e);
    run(OP_STACK_ADJUST, 16'h0005);
    chk(regs.sp, 32'h1283);
    run(OP_STACK_LOW_RESET, 16'h0);
    chk(regs.sp, 32'h12ff);
    slow <= 1'b1;
    run(OP_MASK_SET, 16'h0);
    irq_req <= 1'b1;
    bound(t);
    chk(t, 0);
    run(OP_MASK_CLEAR, 16'h0);
    bound(t);
    chk(t, 0);
    bound(t);
    chk(t, 1);
    irq_req <= 1'b0;
    run(OP_NOP, 16'h0);
    for (int i = 0; i < 5; i++) chk(mem_u.m[16'h12ff - i], pushed[i]);
    chk(regs.sp, 32'h12fa);
    chk(regs.pc, 32'h5678);
    chk(regs.flags, 32'h68);
    run(OP_FETCH, 16'h0);
    chk(regs.pc, 32'h5679);
    results();
  end
endmodule : cpu_register_file_flags_test
`default_nettype wire
